// file: tccc_core.sv
// Summary of operation
// - Comparator count reads in control bits 31:28; zero means no comparators.
// - Read-only bit 27 set means no trace sampling or exception trace.
// - Read-only bit 26 set means no per-comparator match outputs.
// - Bit 25 set means no cycle counter; counter reads zero, ignores writes.
// - Bit 24 set means no profile counters; bits 21:17 become reserved.
// - Bits 21:17 enable five profile counter overflow events, reset zero.
// - Cycle-event and PC-sample enables select event kind from post-scaler.
// - Bit 16 enables exception entry, exit and return tracing, reset zero.
// - Sync tap 00 off, 01 bit 24, 10 bit 26, 11 bit 28.
// - Sync request on each tap transition while counter and sync enabled.
// - Cycle tap picks bit 6 or 10; each transition is a count event.
// - Post-scaler decrements on count events while above one.
// - Count event at post-scaler zero reloads it from the preset.
// - Counter enable resets zero; reads zero, ignores writes without counter.
// - Counter, taps, post-scaler and preset need no defined reset value.
// - Enabled counter increments each core cycle; software reads and writes it.
// - Counter stops while the core is halted in debug state.
// - Counter wraps from maximum to zero and keeps counting.
// - Without trace packets bits 22, 16, 12 reserved; with them counter required.
// - Without counter bits 22 and 12:0 reserved; comparator zero bit 7 reads zero.
`timescale 1ns/1ps
`default_nettype none
module tccc_core #(
  parameter logic [3:0] NUM_COMPARATORS = 4'h4,
  parameter bit NO_TRACE_PACKETS = 1'b0,
  parameter bit NO_MATCH_OUTPUTS = 1'b0,
  parameter bit NO_CYCLE_COUNTER = 1'b0,
  parameter bit NO_PROFILE_COUNTERS = 1'b0
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic CORE_HALTED,
  input wire logic TRACE_SYNC_ENABLE,
  output logic SYNC_REQUEST,
  output logic CYCLE_EVENT,
  output logic PC_SAMPLE_EVENT,
  output logic [4:0] PROFILE_EVENT_ENABLE,
  output logic EXCEPTION_TRACE_ENABLE,
  output logic COMP0_CYCLE_MATCH_ALLOWED
);
  import tccc_pkg::*;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // Refuse a build that offers trace packets without the cycle counter.
  if (!NO_TRACE_PACKETS && NO_CYCLE_COUNTER) begin : g_bad_build
    $error("Trace packets need the cycle counter.");
  end

  // Capability bits, constant per build.
  localparam bit HAS_CYC = !NO_CYCLE_COUNTER;
  localparam bit HAS_TRC = !NO_TRACE_PACKETS && HAS_CYC;
  localparam bit HAS_PRF = !NO_PROFILE_COUNTERS;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic halt_s1_q, halt_q, synce_s1_q, synce_q;

  // Halt status and sync enable come from other logic; double flop them.
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      halt_s1_q <= 1'b0;
      halt_q <= 1'b0;
      synce_s1_q <= 1'b0;
      synce_q <= 1'b0;
    end else begin
      halt_s1_q <= CORE_HALTED;
      halt_q <= halt_s1_q;
      synce_s1_q <= TRACE_SYNC_ENABLE;
      synce_q <= synce_s1_q;
    end
  end

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  logic dph_q, dph_wr_q, dph_ctrl_q, dph_cyc_q;
  logic addr_ok;

  assign addr_ok = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ) && (HSIZE == HSIZE_WORD);

  // Capture the address phase; the data phase always completes at once.
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      dph_q <= 1'b0;
      dph_wr_q <= 1'b0;
      dph_ctrl_q <= 1'b0;
      dph_cyc_q <= 1'b0;
    end else begin
      dph_q <= addr_ok;
      dph_wr_q <= addr_ok && HWRITE;
      dph_ctrl_q <= addr_ok && (HADDR == ADDR_CTRL);
      dph_cyc_q <= addr_ok && (HADDR == ADDR_CYCLE_COUNTER_VALUE);
    end
  end

  logic wr_ctrl, wr_cyc;
  assign wr_ctrl = dph_wr_q && dph_ctrl_q;
  assign wr_cyc = dph_wr_q && dph_cyc_q;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  logic cyc_ena_q, cyc_evt_q, pc_samp_q, exc_trc_q;
  logic [4:0] prf_q;
  logic [1:0] sync_tap_q;
  logic cyc_tap_q;
  logic [3:0] post_q, preset_q;
  logic [31:0] cnt_q;

  // Reset-zero enables; absent features keep their bits at zero.
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cyc_ena_q <= 1'b0;
      cyc_evt_q <= 1'b0;
      pc_samp_q <= 1'b0;
      exc_trc_q <= 1'b0;
      prf_q <= PRF_RESET;
    end else if (wr_ctrl) begin
      cyc_ena_q <= HAS_CYC && HWDATA[F_CYCENA];
      cyc_evt_q <= HAS_TRC && HWDATA[F_CYCEVT];
      pc_samp_q <= HAS_TRC && HWDATA[F_PCSAMP];
      exc_trc_q <= !NO_TRACE_PACKETS && HWDATA[F_EXCTRC];
      prf_q <= HAS_PRF ? HWDATA[F_PRF_HI:F_PRF_LO] : PRF_RESET;
    end
  end

  // Tap and preset fields carry no reset; they hold what software wrote.
  always_ff @(posedge SYS_CLK) begin
    if (wr_ctrl && HAS_CYC) begin
      sync_tap_q <= HWDATA[F_SYNC_LO+1:F_SYNC_LO];
      cyc_tap_q <= HWDATA[F_CYCLE_TAP_SELECT];
      preset_q <= HWDATA[F_PRESET_LO+POST_W-1:F_PRESET_LO];
    end
  end

  // ****************************************************************
  // Cycle counter
  // ****************************************************************
  logic count_en;
  assign count_en = HAS_CYC && cyc_ena_q && !halt_q;

  // Free-running count, frozen in debug halt, wrapping at the top; software
  // write wins over the increment in the same cycle.
  always_ff @(posedge SYS_CLK) begin
    if (!HAS_CYC) begin
      cnt_q <= '0;
    end else if (wr_cyc) begin
      cnt_q <= HWDATA;
    end else if (count_en) begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  // ****************************************************************
  // Taps and event generation
  // ****************************************************************
  logic cyc_tap_bit, sync_tap_bit, count_evt, sync_evt, sync_on;

  assign cyc_tap_bit = cyc_tap_q ? cnt_q[TAP_CYC_HI] : cnt_q[TAP_CYC_LO];

  // Select the sync tap bit.
  always_comb begin
    unique case (sync_tap_q)
      SYNC_B24: sync_tap_bit = cnt_q[TAP_SYNC_01];
      SYNC_B26: sync_tap_bit = cnt_q[TAP_SYNC_10];
      default: sync_tap_bit = cnt_q[TAP_SYNC_11];
    endcase
  end

  assign sync_on = count_en && synce_q && (sync_tap_q != SYNC_OFF);

  tccc_edge u_cyc_edge (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .tap(cyc_tap_bit),
    .ena(count_en),
    .evt(count_evt)
  );

  tccc_edge u_sync_edge (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .tap(sync_tap_bit),
    .ena(sync_on),
    .evt(sync_evt)
  );

  // Post-scaler: a count event decrements it above one, reloads it at zero.
  // At exactly one it stays put, as documented.
  logic reload;
  assign reload = count_evt && (post_q == POST_ZERO);

  always_ff @(posedge SYS_CLK) begin
    if (wr_ctrl && HAS_CYC) begin
      post_q <= HWDATA[F_POST_LO+POST_W-1:F_POST_LO];
    end else if (reload) begin
      post_q <= preset_q;
    end else if (count_evt && (post_q > POST_ONE)) begin
      post_q <= post_q - POST_ONE;
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      SYNC_REQUEST <= 1'b0;
      CYCLE_EVENT <= 1'b0;
      PC_SAMPLE_EVENT <= 1'b0;
      PROFILE_EVENT_ENABLE <= PRF_RESET;
      EXCEPTION_TRACE_ENABLE <= 1'b0;
      COMP0_CYCLE_MATCH_ALLOWED <= 1'b0;
    end else begin
      SYNC_REQUEST <= sync_evt;
      PC_SAMPLE_EVENT <= reload && pc_samp_q;
      CYCLE_EVENT <= reload && cyc_evt_q && !pc_samp_q;
      PROFILE_EVENT_ENABLE <= prf_q;
      EXCEPTION_TRACE_ENABLE <= exc_trc_q;
      COMP0_CYCLE_MATCH_ALLOWED <= HAS_CYC;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [31:0] ctrl_rd;

  // Assemble the control word; reserved and absent fields read zero.
  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[31:F_COMPARATOR_COUNT_LO] = NUM_COMPARATORS;
    ctrl_rd[F_NOTRC] = NO_TRACE_PACKETS;
    ctrl_rd[F_NOMATCH] = NO_MATCH_OUTPUTS;
    ctrl_rd[F_NOCYC] = NO_CYCLE_COUNTER;
    ctrl_rd[F_NOPRF] = NO_PROFILE_COUNTERS;
    ctrl_rd[F_CYCEVT] = cyc_evt_q;
    ctrl_rd[F_PRF_HI:F_PRF_LO] = prf_q;
    ctrl_rd[F_EXCTRC] = exc_trc_q;
    ctrl_rd[F_PCSAMP] = pc_samp_q;
    if (HAS_CYC) begin
      ctrl_rd[F_SYNC_LO+1:F_SYNC_LO] = sync_tap_q;
      ctrl_rd[F_CYCLE_TAP_SELECT] = cyc_tap_q;
      ctrl_rd[F_POST_LO+POST_W-1:F_POST_LO] = post_q;
      ctrl_rd[F_PRESET_LO+POST_W-1:F_PRESET_LO] = preset_q;
      ctrl_rd[F_CYCENA] = cyc_ena_q;
    end
  end

  // Read data stands during the data phase; unmapped reads give zero.
  // A read whose address phase meets the data phase of a write sees the old
  // value, so a master must let one idle cycle pass between such a pair.
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      HRDATA <= '0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      if (addr_ok && !HWRITE && HADDR == ADDR_CTRL) begin
        HRDATA <= ctrl_rd;
      end else if (addr_ok && !HWRITE && HADDR == ADDR_CYCLE_COUNTER_VALUE) begin
        HRDATA <= cnt_q;
      end else begin
        HRDATA <= '0;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_evt_at_zero;
    count_evt && post_q == POST_ZERO;
  endsequence

  sequence s_cyc_reload;
    s_evt_at_zero ##0 (cyc_evt_q && !pc_samp_q);
  endsequence

  a_post_reload: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    s_evt_at_zero |=> post_q == $past(preset_q) || $past(wr_ctrl))
    else $error("Post-scaler failed to reload.");

  a_post_dec: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    count_evt && post_q > POST_ONE && !wr_ctrl |=> post_q == $past(post_q) - POST_ONE)
    else $error("Post-scaler failed to decrement.");

  a_cnt_inc: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    count_en && !wr_cyc |=> cnt_q == $past(cnt_q) + 32'h1)
    else $error("Counter did not increment.");

  a_cnt_halt: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    halt_q && !wr_cyc |=> $stable(cnt_q))
    else $error("Counter moved during halt.");

  a_cnt_wrap: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    count_en && !wr_cyc && cnt_q == 32'hffffffff |=> cnt_q == 32'h0)
    else $error("Counter did not wrap.");

  a_sync_gate: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !(count_en && synce_q) |=> !SYNC_REQUEST)
    else $error("Sync request while disabled.");

  a_event_pulse: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    s_evt_at_zero ##0 pc_samp_q |=> PC_SAMPLE_EVENT ##1 !PC_SAMPLE_EVENT)
    else $error("PC sample event not a single pulse.");

  a_ahb_ready: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    HREADYOUT && !HRESP)
    else $error("Slave stalled or errored.");

  a_cycle_pulse: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    s_cyc_reload |=> CYCLE_EVENT ##1 !CYCLE_EVENT)
    else $error("Cycle event not a single pulse.");

  a_event_select: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    PC_SAMPLE_EVENT |-> !CYCLE_EVENT)
    else $error("Cycle event and PC sample event at once.");

  a_sync_pulse: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    sync_evt |=> SYNC_REQUEST)
    else $error("Sync request missing after tap transition.");

  a_cyc_tap: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    count_en && $stable(cyc_tap_q) &&
      (cyc_tap_q ? cnt_q[TAP_CYC_HI] != $past(cnt_q[TAP_CYC_HI]) :
                   cnt_q[TAP_CYC_LO] != $past(cnt_q[TAP_CYC_LO])) |-> count_evt)
    else $error("Cycle tap transition gave no count event.");

  a_enable_out: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    PROFILE_EVENT_ENABLE == $past(prf_q) && EXCEPTION_TRACE_ENABLE == $past(exc_trc_q))
    else $error("Enable outputs do not follow the control register.");
endmodule // tccc_core
`default_nettype wire

// file: tccc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stands in for the processor core and the trace output unit.
module tccc_core_model (
  input wire logic clk,
  input wire logic halt_cmd,
  input wire logic sync_cmd,
  output logic halted,
  output logic sync_en
);
  // Halt status and sync enable change only after a clock edge, as a real core would.
  always_ff @(posedge clk) begin
    halted <= halt_cmd;
    sync_en <= sync_cmd;
  end
endmodule // tccc_core_model
`default_nettype wire

// file: tccc_edge.sv
`timescale 1ns/1ps
`default_nettype none
// Detects any transition of one tap bit while enabled.
module tccc_edge (
  input wire logic clk,
  input wire logic rst,
  input wire logic tap,
  input wire logic ena,
  output logic evt
);
  logic tap_q;

  // Hold last tap level; report a change only while counting is enabled.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tap_q <= 1'b0;
    end else begin
      tap_q <= tap;
    end
  end

  assign evt = ena && (tap != tap_q);
endmodule // tccc_edge
`default_nettype wire

// file: tccc_pkg.sv
package tccc_pkg;
  // Register byte addresses on the bus.
  localparam logic [31:0] ADDR_CTRL = 32'he0001000;
  localparam logic [31:0] ADDR_CYCLE_COUNTER_VALUE = 32'he0001004;
  // Control register field positions.
  localparam int F_COMPARATOR_COUNT_LO = 28;
  localparam int F_NOTRC = 27;
  localparam int F_NOMATCH = 26;
  localparam int F_NOCYC = 25;
  localparam int F_NOPRF = 24;
  localparam int F_CYCEVT = 22;
  localparam int F_PRF_HI = 21;
  localparam int F_PRF_LO = 17;
  localparam int F_EXCTRC = 16;
  localparam int F_PCSAMP = 12;
  localparam int F_SYNC_LO = 10;
  localparam int F_CYCLE_TAP_SELECT = 9;
  localparam int F_POST_LO = 5;
  localparam int F_PRESET_LO = 1;
  localparam int F_CYCENA = 0;
  // Cycle counter tap bit positions.
  localparam int TAP_CYC_LO = 6;
  localparam int TAP_CYC_HI = 10;
  localparam int TAP_SYNC_01 = 24;
  localparam int TAP_SYNC_10 = 26;
  localparam int TAP_SYNC_11 = 28;
  // Synchronization tap encodings.
  localparam logic [1:0] SYNC_OFF = 2'h0;
  localparam logic [1:0] SYNC_B24 = 2'h1;
  localparam logic [1:0] SYNC_B26 = 2'h2;
  // Widths and reset values.
  localparam int POST_W = 4;
  localparam logic [3:0] POST_ONE = 4'h1;
  localparam logic [3:0] POST_ZERO = 4'h0;
  localparam logic [4:0] PRF_RESET = 5'h00;
  // AHB encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : tccc_pkg

// file: trace_cycle_counter_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module trace_cycle_counter_control_test;
  import tccc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic halt_cmd = 1'b0, sync_cmd = 1'b0;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, halted, sync_en, sync_req, cyc_evt, pc_evt, exc_ena, c0_ok;
  wire logic [4:0] prf_ena;
  int failures = 0, check_count = 0;
  // ****************************************************************
  // Clock, device and core model.
  // ****************************************************************
  // The clock runs at 50 MHz.
  always #10 clk = ~clk;
  tccc_core uut (.SYS_CLK(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HREADY(hreadyout), .HWDATA(hwdata), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .CORE_HALTED(halted), .TRACE_SYNC_ENABLE(sync_en),
    .SYNC_REQUEST(sync_req), .CYCLE_EVENT(cyc_evt), .PC_SAMPLE_EVENT(pc_evt),
    .PROFILE_EVENT_ENABLE(prf_ena), .EXCEPTION_TRACE_ENABLE(exc_ena),
    .COMP0_CYCLE_MATCH_ALLOWED(c0_ok));
  tccc_core_model core (.clk(clk), .halt_cmd(halt_cmd), .sync_cmd(sync_cmd), .halted(halted),
    .sync_en(sync_en));
  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  // Prints the verdict and ends the run.
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d.", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Compares a seen value with the expected one.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Waits for the next edge at which the slave is ready, with a bound.
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n >= 50) begin
      failures++;
      finish_test();
    end
  endtask
  // One single word transfer; read data is taken at the end of the data phase.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask
  // Builds a control word from its writable fields.
  function automatic logic [31:0] mk(input logic ce, pc, input logic [1:0] st, input logic ct,
                                     input logic [3:0] po, pr, input logic en);
    mk = {9'h0, ce, 9'h0, pc, st, ct, po, pr, en};
  endfunction
  // Counts event pulses over a number of cycles.
  task automatic count(input int n, output int c_cyc, c_pc, c_sync);
    c_cyc = 0;
    c_pc = 0;
    c_sync = 0;
    repeat (n) begin
      @(posedge clk);
      if (cyc_evt === 1'b1) c_cyc++;
      if (pc_evt === 1'b1) c_pc++;
      if (sync_req === 1'b1) c_sync++;
    end
  endtask
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  localparam logic [3:0] NUM_COMP_EXP = 4'h4;
  // Capability fields, reset enables and read-only behaviour.
  task automatic t_control();
    logic [31:0] rd;
    bus(1'b0, ADDR_CTRL, 32'h0, rd);
    check("caps", {24'h0, rd[31:24]}, {24'h0, NUM_COMP_EXP, 4'h0});
    check("rst_ena", {rd[22:16], rd[12], rd[0]}, 32'h0);
    check("c0", {31'h0, c0_ok}, 32'h1);
    bus(1'b1, ADDR_CTRL, 32'hff3f_0000, rd);
    bus(1'b0, ADDR_CTRL, 32'h0, rd);
    check("ro_caps", {24'h0, rd[31:24]}, {24'h0, NUM_COMP_EXP, 4'h0});
    check("prf_rd", {26'h0, rd[21:16]}, 32'h3f);
    check("prf_out", {26'h0, prf_ena, exc_ena}, 32'h3f);
    bus(1'b1, ADDR_CTRL, 32'h0, rd);
    bus(1'b0, ADDR_CTRL + 32'h8, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    check("prf_off", {26'h0, prf_ena, exc_ena}, 32'h0);
  endtask
  // Read-write counter, increment, halt and wrap.
  task automatic t_counter();
    logic [31:0] a, b;
    bus(1'b1, ADDR_CYCLE_COUNTER_VALUE, 32'hffff_fffe, a);
    bus(1'b0, ADDR_CYCLE_COUNTER_VALUE, 32'h0, a);
    check("cnt_rw", a, 32'hffff_fffe);
    bus(1'b1, ADDR_CTRL, mk(1'b0, 1'b0, 2'h0, 1'b0, 4'h0, 4'h0, 1'b1), a);
    // Let the counter pass its top value before reading it back.
    repeat (4) @(posedge clk);
    bus(1'b0, ADDR_CYCLE_COUNTER_VALUE, 32'h0, a);
    check("wrap", {3'h0, a[31:3]}, 32'h0);
    bus(1'b0, ADDR_CYCLE_COUNTER_VALUE, 32'h0, a);
    bus(1'b0, ADDR_CYCLE_COUNTER_VALUE, 32'h0, b);
    check("incr", b - a, 32'h2);
    halt_cmd <= 1'b1;
    repeat (6) @(posedge clk);
    bus(1'b0, ADDR_CYCLE_COUNTER_VALUE, 32'h0, a);
    bus(1'b0, ADDR_CYCLE_COUNTER_VALUE, 32'h0, b);
    check("halt", b - a, 32'h0);
    halt_cmd <= 1'b0;
  endtask
  // Post-scaler reload, decrement and event selection.
  task automatic t_events(input logic ce, pc, input logic [3:0] pr, input int e_cyc, e_pc);
    logic [31:0] rd;
    int c, p, s;
    bus(1'b1, ADDR_CTRL, mk(ce, pc, 2'h0, 1'b0, 4'h0, pr, 1'b0), rd);
    bus(1'b1, ADDR_CYCLE_COUNTER_VALUE, 32'h0, rd);
    bus(1'b1, ADDR_CTRL, mk(ce, pc, 2'h0, 1'b0, 4'h0, pr, 1'b1), rd);
    count(672, c, p, s);
    check("cyc_evts", c, e_cyc);
    check("pc_evts", p, e_pc);
    bus(1'b0, ADDR_CTRL, 32'h0, rd);
    if (pr == 4'h2) check("post_hold", {28'h0, rd[8:5]}, 32'h1);
  endtask
  // Sync requests on tap transitions for each tap setting.
  task automatic t_sync(input logic [1:0] st, input int bitpos, input logic se, input int e);
    logic [31:0] rd;
    int c, p, s;
    sync_cmd <= se;
    bus(1'b1, ADDR_CTRL, mk(1'b1, 1'b0, st, 1'b1, 4'h0, 4'h0, 1'b0), rd);
    bus(1'b1, ADDR_CYCLE_COUNTER_VALUE, (32'h1 << bitpos) - 32'h14, rd);
    bus(1'b1, ADDR_CTRL, mk(1'b1, 1'b0, st, 1'b1, 4'h0, 4'h0, 1'b1), rd);
    // In this window bit 10 turns once, while bit 6 would turn twice.
    count(100, c, p, s);
    check("sync_reqs", s, e);
    check("cyc_tap10", c, 32'h1);
  endtask
  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  // Reset for six cycles, then run every scenario.
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_control();
    t_counter();
    t_events(1'b1, 1'b0, 4'h0, 10, 0);
    t_events(1'b1, 1'b1, 4'h0, 0, 10);
    t_events(1'b1, 1'b0, 4'h2, 1, 0);
    t_sync(SYNC_B24, TAP_SYNC_01, 1'b1, 1);
    t_sync(SYNC_B26, TAP_SYNC_10, 1'b1, 1);
    t_sync(2'h3, TAP_SYNC_11, 1'b1, 1);
    t_sync(SYNC_OFF, TAP_SYNC_01, 1'b1, 0);
    t_sync(SYNC_B24, TAP_SYNC_01, 1'b0, 0);
    finish_test();
  end
endmodule // trace_cycle_counter_control_test
`default_nettype wire
